// [common/tmr_pkg.sv]
// package of constants for the temperature monitor register bank
package tmr_pkg;
   // ==========================================================
   // read addresses
   localparam logic [7:0] RD_LOCAL_VAL   = 8'h00;
   localparam logic [7:0] RD_REMOTE_HI   = 8'h01;
   localparam logic [7:0] RD_STATUS      = 8'h02;
   localparam logic [7:0] RD_CONFIG      = 8'h03;
   localparam logic [7:0] RD_RATE        = 8'h04;
   localparam logic [7:0] RD_LOC_HLIM    = 8'h05;
   localparam logic [7:0] RD_LOC_LLIM    = 8'h06;
   localparam logic [7:0] RD_REM_HLIM_HI = 8'h07;
   localparam logic [7:0] RD_REM_LLIM_HI = 8'h08;
   localparam logic [7:0] RD_REMOTE_LO   = 8'h10;
   localparam logic [7:0] RD_RSVD_A      = 8'h19;
   localparam logic [7:0] RD_RSVD_B      = 8'h20;
   localparam logic [7:0] RD_MAKER_ID    = 8'hfe;
   localparam logic [7:0] RD_REVISION    = 8'hff;
   // ==========================================================
   // write addresses
   localparam logic [7:0] WR_CONFIG      = 8'h09;
   localparam logic [7:0] WR_RATE        = 8'h0a;
   localparam logic [7:0] WR_LOC_HLIM    = 8'h0b;
   localparam logic [7:0] WR_LOC_LLIM    = 8'h0c;
   localparam logic [7:0] WR_REM_HLIM_HI = 8'h0d;
   localparam logic [7:0] WR_REM_LLIM_HI = 8'h0e;
   localparam logic [7:0] WR_ONE_SHOT    = 8'h0f;
   // shared read/write addresses
   localparam logic [7:0] RW_OFFSET_HI   = 8'h11;
   localparam logic [7:0] RW_OFFSET_LO   = 8'h12;
   localparam logic [7:0] RW_REM_HLIM_LO = 8'h13;
   localparam logic [7:0] RW_REM_LLIM_LO = 8'h14;
   // ==========================================================
   // reset values and fixed answers
   localparam logic [7:0] RST_TEMP       = 8'h80;
   localparam logic [7:0] RST_CONFIG     = 8'h00;
   localparam logic [7:0] RST_RATE       = 8'h02;
   localparam logic [7:0] RST_HIGH_LIM   = 8'h7f;
   localparam logic [7:0] RST_LOW_LIM    = 8'hc9;
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] INVALID_READ   = 8'hff;
   // ==========================================================
   // field positions, widths and remote limits
   localparam int CFG_ALERT_SUPPRESS = 7;
   localparam int CFG_STANDBY        = 6;
   localparam int ST_BUSY            = 7;
   localparam int ST_FLAG_TOP        = 6;
   localparam int FRAC_BITS          = 3;
   localparam int REMOTE_W           = 11;
   localparam logic [10:0] REMOTE_MAX = 11'h3ff;
   localparam logic [10:0] REMOTE_MIN = 11'h400;
   // ==========================================================
   // conversion sequencer
   typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_CMP} tmr_conv_t;
endpackage : tmr_pkg

// [hw/tmr_regs.sv]
// register bank, conversion sequencer, status flags and alert latch
`timescale 1ns/1ps
module tmr_regs #(
   parameter logic [7:0] MAKER_ID = 8'h5a,   // arbitrary value
   parameter logic [7:0] REV_ID   = 8'h01    // arbitrary value
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // byte port from serial framing
   input  wire logic       bus_wr_stb,
   input  wire logic       bus_wr_first,
   input  wire logic [7:0] bus_wr_data,
   input  wire logic       bus_rd_stb,
   input  wire logic       alert_resp_stb,
   output logic      [7:0] bus_rd_data_q,
   output logic            bus_rd_valid_q,
   // converter
   output logic            conv_start_q,
   input  wire logic       conv_done,
   input  wire logic [7:0] meas_local,
   input  wire logic [10:0] meas_remote,
   input  wire logic       meas_open,
   // pins
   input  wire logic       standby_pin_n,
   output logic            alert_n_q
);
   // ==========================================================
   // registers
   tmr_pkg::tmr_conv_t state_q;
   logic [7:0]  ptr_q;
   logic [7:0]  local_q, remote_hi_q, remote_lo_q;
   logic [7:0]  cfg_q, rate_q, loc_hlim_q, loc_llim_q;
   logic [7:0]  rem_hlim_hi_q, rem_llim_hi_q, rem_hlim_lo_q, rem_llim_lo_q;
   logic [7:0]  off_hi_q, off_lo_q;
   logic        open_q, oneshot_pend_q, oneshot_act_q, latch_q;
   logic [4:0]  flags_q;
   logic [4:0]  cause;
   logic        run, wr_data, accept, busy, start;
   logic [11:0] sum;
   logic [10:0] remote_sat, remote_now, rem_hlim, rem_llim, offset;

   // ==========================================================
   // decode and datapath
   assign wr_data    = bus_wr_stb && !bus_wr_first;
   assign run        = !cfg_q[tmr_pkg::CFG_STANDBY] && standby_pin_n;
   assign busy       = state_q != tmr_pkg::CONV_IDLE;
   assign start      = !busy && (run || oneshot_pend_q);
   assign accept     = state_q == tmr_pkg::CONV_RUN && conv_done && (run || oneshot_act_q);
   assign offset     = {off_hi_q, off_lo_q[7:5]};
   assign sum        = {meas_remote[10], meas_remote} + {offset[10], offset};
   assign remote_sat = (sum[11] != sum[10]) ? (sum[11] ? tmr_pkg::REMOTE_MIN
                                                        : tmr_pkg::REMOTE_MAX)
                                            : sum[10:0];
   assign remote_now = {remote_hi_q, remote_lo_q[7:5]};
   assign rem_hlim   = {rem_hlim_hi_q, rem_hlim_lo_q[7:5]};
   assign rem_llim   = {rem_llim_hi_q, rem_llim_lo_q[7:5]};
   // causes: local high, local low, remote high, remote low, open
   assign cause[4]   = $signed(local_q) > $signed(loc_hlim_q);
   assign cause[3]   = $signed(local_q) < $signed(loc_llim_q);
   assign cause[2]   = $signed(remote_now) > $signed(rem_hlim);
   assign cause[1]   = $signed(remote_now) < $signed(rem_llim);
   assign cause[0]   = open_q;

   // ==========================================================
   // address pointer
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         ptr_q <= 8'h00;
      else if (bus_wr_stb && bus_wr_first)
         ptr_q <= bus_wr_data;
   end

   // ==========================================================
   // writable registers; read-only and reserved addresses ignore writes
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfg_q         <= tmr_pkg::RST_CONFIG;
         rate_q        <= tmr_pkg::RST_RATE;
         loc_hlim_q    <= tmr_pkg::RST_HIGH_LIM;
         loc_llim_q    <= tmr_pkg::RST_LOW_LIM;
         rem_hlim_hi_q <= tmr_pkg::RST_HIGH_LIM;
         rem_llim_hi_q <= tmr_pkg::RST_LOW_LIM;
         rem_hlim_lo_q <= tmr_pkg::RST_ZERO;
         rem_llim_lo_q <= tmr_pkg::RST_ZERO;
         off_hi_q      <= tmr_pkg::RST_ZERO;
         off_lo_q      <= tmr_pkg::RST_ZERO;
      end
      else if (wr_data)
      begin
         case (ptr_q)
            tmr_pkg::WR_CONFIG:      cfg_q         <= bus_wr_data;
            tmr_pkg::WR_RATE:        rate_q        <= bus_wr_data;
            tmr_pkg::WR_LOC_HLIM:    loc_hlim_q    <= bus_wr_data;
            tmr_pkg::WR_LOC_LLIM:    loc_llim_q    <= bus_wr_data;
            tmr_pkg::WR_REM_HLIM_HI: rem_hlim_hi_q <= bus_wr_data;
            tmr_pkg::WR_REM_LLIM_HI: rem_llim_hi_q <= bus_wr_data;
            tmr_pkg::RW_OFFSET_HI:   off_hi_q      <= bus_wr_data;
            tmr_pkg::RW_OFFSET_LO:   off_lo_q      <= bus_wr_data;
            tmr_pkg::RW_REM_HLIM_LO: rem_hlim_lo_q <= bus_wr_data;
            tmr_pkg::RW_REM_LLIM_LO: rem_llim_lo_q <= bus_wr_data;
            default:                 ;
         endcase
      end
   end

   // ==========================================================
   // one-shot request, held until a conversion can start
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         oneshot_pend_q <= 1'b0;
      else if (wr_data && ptr_q == tmr_pkg::WR_ONE_SHOT)
         oneshot_pend_q <= 1'b1;
      else if (start)
         oneshot_pend_q <= 1'b0;
   end

   // ==========================================================
   // conversion sequencer
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q       <= tmr_pkg::CONV_IDLE;
         conv_start_q  <= 1'b0;
         oneshot_act_q <= 1'b0;
      end
      else
      begin
         conv_start_q <= 1'b0;
         case (state_q)
            tmr_pkg::CONV_IDLE:
            begin
               if (start)
               begin
                  state_q       <= tmr_pkg::CONV_RUN;
                  conv_start_q  <= 1'b1;
                  oneshot_act_q <= !run;
               end
            end
            tmr_pkg::CONV_RUN:
            begin
               if (conv_done)
                  state_q <= accept ? tmr_pkg::CONV_CMP : tmr_pkg::CONV_IDLE;
            end
            tmr_pkg::CONV_CMP:
            begin
               state_q       <= tmr_pkg::CONV_IDLE;
               oneshot_act_q <= 1'b0;
            end
            default: state_q <= tmr_pkg::CONV_IDLE;
         endcase
      end
   end

   // ==========================================================
   // value registers, written only by the converter
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         local_q     <= tmr_pkg::RST_TEMP;
         remote_hi_q <= tmr_pkg::RST_TEMP;
         remote_lo_q <= tmr_pkg::RST_ZERO;
         open_q      <= 1'b0;
      end
      else if (accept)
      begin
         local_q     <= meas_local;
         remote_hi_q <= remote_sat[10:tmr_pkg::FRAC_BITS];
         remote_lo_q <= {remote_sat[tmr_pkg::FRAC_BITS-1:0], 5'b00000};
         open_q      <= meas_open;
      end
   end

   // ==========================================================
   // sticky flags: set wins over the clear of a status read
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         flags_q <= 5'h00;
      else
      begin
         for (int i = 0; i < 5; i++)
         begin
            if (state_q == tmr_pkg::CONV_CMP && cause[i])
               flags_q[i] <= 1'b1;
            else if (bus_rd_stb && ptr_q == tmr_pkg::RD_STATUS && !cause[i])
               flags_q[i] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // interrupt latch and alert pin
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         latch_q <= 1'b0;
      else if (|flags_q)
         latch_q <= 1'b1;
      else if (alert_resp_stb && cause == 5'h00)
         latch_q <= 1'b0;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         alert_n_q <= 1'b1;
      else
         alert_n_q <= !(latch_q && !cfg_q[tmr_pkg::CFG_ALERT_SUPPRESS]);
   end

   // ==========================================================
   // read port; write-only addresses answer with an invalid byte
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bus_rd_data_q  <= 8'h00;
         bus_rd_valid_q <= 1'b0;
      end
      else
      begin
         bus_rd_valid_q <= bus_rd_stb;
         if (bus_rd_stb)
         begin
            case (ptr_q)
               tmr_pkg::RD_LOCAL_VAL:   bus_rd_data_q <= local_q;
               tmr_pkg::RD_REMOTE_HI:   bus_rd_data_q <= remote_hi_q;
               tmr_pkg::RD_STATUS:      bus_rd_data_q <= {busy, flags_q, 2'b00};
               tmr_pkg::RD_CONFIG:      bus_rd_data_q <= cfg_q;
               tmr_pkg::RD_RATE:        bus_rd_data_q <= rate_q;
               tmr_pkg::RD_LOC_HLIM:    bus_rd_data_q <= loc_hlim_q;
               tmr_pkg::RD_LOC_LLIM:    bus_rd_data_q <= loc_llim_q;
               tmr_pkg::RD_REM_HLIM_HI: bus_rd_data_q <= rem_hlim_hi_q;
               tmr_pkg::RD_REM_LLIM_HI: bus_rd_data_q <= rem_llim_hi_q;
               tmr_pkg::RD_REMOTE_LO:   bus_rd_data_q <= remote_lo_q;
               tmr_pkg::RW_OFFSET_HI:   bus_rd_data_q <= off_hi_q;
               tmr_pkg::RW_OFFSET_LO:   bus_rd_data_q <= off_lo_q;
               tmr_pkg::RW_REM_HLIM_LO: bus_rd_data_q <= rem_hlim_lo_q;
               tmr_pkg::RW_REM_LLIM_LO: bus_rd_data_q <= rem_llim_lo_q;
               tmr_pkg::RD_RSVD_A:      bus_rd_data_q <= tmr_pkg::RST_ZERO;
               tmr_pkg::RD_RSVD_B:      bus_rd_data_q <= tmr_pkg::RST_ZERO;
               tmr_pkg::RD_MAKER_ID:    bus_rd_data_q <= MAKER_ID;
               tmr_pkg::RD_REVISION:    bus_rd_data_q <= REV_ID;
               default:                 bus_rd_data_q <= tmr_pkg::INVALID_READ;
            endcase
         end
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_frac_low_zero;
      remote_lo_q[4:0] == 5'b00000;
   endproperty
   a_frac_low_zero: assert property (p_frac_low_zero) else $error("remote low byte low bits set");

   property p_pointer_load;
      bus_wr_stb && bus_wr_first |=> ptr_q == $past(bus_wr_data);
   endproperty
   a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded");

   property p_value_ro;
      $changed(local_q) || $changed(remote_hi_q) |-> $past(accept);
   endproperty
   a_value_ro: assert property (p_value_ro) else $error("value changed without conversion");

   property p_saturate;
      accept && sum[11:10] == 2'b01 |=> remote_now == tmr_pkg::REMOTE_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("positive overflow not saturated");

   property p_oneshot;
      wr_data && ptr_q == tmr_pkg::WR_ONE_SHOT && !busy |=> ##1 conv_start_q;
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot did not start");

   property p_busy_bit;
      bus_rd_stb && ptr_q == tmr_pkg::RD_STATUS |=> bus_rd_data_q[tmr_pkg::ST_BUSY] == $past(busy);
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");

   property p_flag_stays;
      flags_q[0] && cause[0] |=> flags_q[0];
   endproperty
   a_flag_stays: assert property (p_flag_stays) else $error("open flag cleared with cause");

   property p_alert;
      (|flags_q && !cfg_q[tmr_pkg::CFG_ALERT_SUPPRESS]) ##1 !cfg_q[tmr_pkg::CFG_ALERT_SUPPRESS] |=> !alert_n_q;
   endproperty
   a_alert: assert property (p_alert) else $error("alert not asserted");

   property p_masked;
      latch_q && cfg_q[tmr_pkg::CFG_ALERT_SUPPRESS] |=> alert_n_q;
   endproperty
   a_masked: assert property (p_masked) else $error("masked alert asserted");

   property p_latch_keep;
      latch_q && !alert_resp_stb |=> latch_q;
   endproperty
   a_latch_keep: assert property (p_latch_keep) else $error("latch cleared without service");

   property p_standby;
      !run && !oneshot_pend_q |=> !conv_start_q;
   endproperty
   a_standby: assert property (p_standby) else $error("conversion started in standby");

   property p_low_reset;
      $fell(sys_rst) |-> loc_llim_q == tmr_pkg::RST_LOW_LIM && rem_llim_hi_q == tmr_pkg::RST_LOW_LIM;
   endproperty
   a_low_reset: assert property (p_low_reset) else $error("low limit reset value wrong");

   property p_offset_add;
      accept && sum[11] == sum[10] |=> {remote_now[10], remote_now} == $past(sum);
   endproperty
   a_offset_add: assert property (p_offset_add) else $error("offset sum not stored");

   property p_flag_set;
      state_q == tmr_pkg::CONV_CMP |=> (flags_q & $past(cause)) == $past(cause);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("limit flag not set");

   property p_open_flag;
      state_q == tmr_pkg::CONV_CMP && open_q |=> flags_q[0];
   endproperty
   a_open_flag: assert property (p_open_flag) else $error("open flag not set");

   property p_flag_clear;
      bus_rd_stb && ptr_q == tmr_pkg::RD_STATUS && state_q != tmr_pkg::CONV_CMP
         |=> (flags_q & ~$past(cause)) == 5'h00;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag kept after cause gone");

   property p_flag_sticky;
      !(bus_rd_stb && ptr_q == tmr_pkg::RD_STATUS) |=> (flags_q & $past(flags_q)) == $past(flags_q);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without status read");

   property p_latch_clear;
      alert_resp_stb && flags_q == 5'h00 && cause == 5'h00 |=> !latch_q;
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared by service");

   property p_hold_standby;
      !run && !oneshot_act_q |=> $stable(local_q) && $stable(remote_hi_q);
   endproperty
   a_hold_standby: assert property (p_hold_standby) else $error("value changed in standby");

   property p_high_strict;
      state_q == tmr_pkg::CONV_CMP && local_q == loc_hlim_q && !flags_q[4] |=> !flags_q[4];
   endproperty
   a_high_strict: assert property (p_high_strict) else $error("high limit tripped on equal");

   property p_oneshot_back;
      state_q == tmr_pkg::CONV_CMP |=> state_q == tmr_pkg::CONV_IDLE && !oneshot_act_q;
   endproperty
   a_oneshot_back: assert property (p_oneshot_back) else $error("cycle did not return");

   property p_update_first;
      accept |=> state_q == tmr_pkg::CONV_CMP && local_q == $past(meas_local);
   endproperty
   a_update_first: assert property (p_update_first) else $error("values not updated before compare");

   property p_invalid_read;
      bus_rd_stb && ptr_q == tmr_pkg::WR_CONFIG |=> bus_rd_data_q == tmr_pkg::INVALID_READ;
   endproperty
   a_invalid_read: assert property (p_invalid_read) else $error("write address read not invalid");

   c_update:  cover property (accept ##1 state_q == tmr_pkg::CONV_CMP);
   c_clear:   cover property (|flags_q ##1 flags_q == 5'h00);
   c_service: cover property (latch_q ##1 !latch_q);
   c_sat:     cover property (accept && sum[11] != sum[10]);
   c_drop:    cover property (state_q == tmr_pkg::CONV_RUN && conv_done && !accept);
endmodule : tmr_regs

// [tb/tmr_conv_model.sv]
// converter model answering each start pulse with one result
`timescale 1ns/1ps
module tmr_conv_model #(
   parameter int DELAY = 20
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // request and result values set by the bench
   input  wire logic        conv_start_q,
   input  wire logic [7:0]  loc_in,
   input  wire logic [10:0] rem_in,
   input  wire logic        open_in,
   // result port
   output logic             conv_done,
   output logic [7:0]       meas_local,
   output logic [10:0]      meas_remote,
   output logic             meas_open
);
   logic       busy_q;
   logic [7:0] cnt_q;
   // ==========================================================
   // conversion timing
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_q    <= 1'b0;
         cnt_q     <= 8'h00;
         conv_done <= 1'b0;
      end
      else
      begin
         conv_done <= 1'b0;
         if (conv_start_q)
         begin
            busy_q <= 1'b1;
            cnt_q  <= 8'h00;
         end
         else if (busy_q && cnt_q == 8'(DELAY - 1))
         begin
            busy_q    <= 1'b0;
            conv_done <= 1'b1;
         end
         else if (busy_q)
            cnt_q <= cnt_q + 8'h01;
      end
   end
   // values only valid with the done pulse; inverted otherwise
   assign meas_local  = conv_done ? loc_in : ~loc_in;
   assign meas_remote = conv_done ? rem_in : ~rem_in;
   assign meas_open   = conv_done ? open_in : ~open_in;
endmodule : tmr_conv_model

// [tb/tmr_regs_test.sv]
// self-checking bench for the temperature monitor register bank
`timescale 1ns/1ps
module tmr_regs_test;
   logic        clk_sys, sys_rst, bus_wr_stb, bus_wr_first, bus_rd_stb, alert_resp_stb;
   logic        standby_pin_n, conv_start_q, conv_done, meas_open, bus_rd_valid_q, alert_n_q, tb_open;
   logic [7:0]  bus_wr_data, bus_rd_data_q, meas_local, tb_local;
   logic [10:0] meas_remote, tb_remote;
   int          miscompares, compares, n_start, n_done, i, k;
   // reset table: address, value
   localparam logic [7:0] RA [19] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10,
                                      8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'hfe, 8'hff, 8'h0f, 8'h09};
   localparam logic [7:0] RV [19] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9, 8'h00,
                                      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h01, 8'hff, 8'hff};
   // saturation table: offset hi, offset lo, measurement, value hi, value lo, status
   localparam logic [7:0]  SOH [2] = '{8'h7f, 8'h80};
   localparam logic [7:0]  SOL [2] = '{8'he0, 8'h00};
   localparam logic [10:0] SM  [2] = '{11'h100, 11'h7f8};
   localparam logic [7:0]  SH  [2] = '{8'h7f, 8'h80};
   localparam logic [7:0]  SL  [2] = '{8'he0, 8'h00};
   localparam logic [7:0]  SS  [2] = '{8'h10, 8'h18};
   // ==========================================================
   // design and converter
   tmr_regs uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_wr_stb(bus_wr_stb), .bus_wr_first(bus_wr_first),
      .bus_wr_data(bus_wr_data), .bus_rd_stb(bus_rd_stb), .alert_resp_stb(alert_resp_stb),
      .bus_rd_data_q(bus_rd_data_q), .bus_rd_valid_q(bus_rd_valid_q), .conv_start_q(conv_start_q),
      .conv_done(conv_done), .meas_local(meas_local), .meas_remote(meas_remote), .meas_open(meas_open),
      .standby_pin_n(standby_pin_n), .alert_n_q(alert_n_q));
   tmr_conv_model u_conv (.clk_sys(clk_sys), .sys_rst(sys_rst), .conv_start_q(conv_start_q),
      .loc_in(tb_local), .rem_in(tb_remote), .open_in(tb_open), .conv_done(conv_done),
      .meas_local(meas_local), .meas_remote(meas_remote), .meas_open(meas_open));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      if (conv_start_q === 1'b1) n_start++;
      if (conv_done === 1'b1) n_done++;
   end
   // ==========================================================
   // tasks
   task automatic end_sim;
      if (miscompares == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys) {bus_wr_stb, bus_wr_first, bus_wr_data} = {2'b11, a};
      @(negedge clk_sys) {bus_wr_first, bus_wr_data} = {1'b0, d};
      @(negedge clk_sys) bus_wr_stb = 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      int n;
      @(negedge clk_sys) {bus_wr_stb, bus_wr_first, bus_wr_data} = {2'b11, a};
      @(negedge clk_sys) {bus_wr_stb, bus_rd_stb} = 2'b01;
      @(negedge clk_sys) bus_rd_stb = 1'b0;
      for (n = 0; n < 4 && bus_rd_valid_q !== 1'b1; n++) @(negedge clk_sys);
      chk("read valid", {7'h00, bus_rd_valid_q}, 8'h01);
      chk($sformatf("read %h", a), bus_rd_data_q, exp);
   endtask : rdc
   task automatic wait_cnt(input bit on_done, input int c0);
      int n;
      for (n = 0; n < 200 && (on_done ? n_done : n_start) == c0; n++) @(negedge clk_sys);
      if ((on_done ? n_done : n_start) == c0)
      begin
         miscompares++;
         end_sim;
      end
   endtask : wait_cnt
   task automatic shot(input bit mid);
      int d;
      d = n_done;
      wr(8'h0f, 8'ha5);
      if (mid) rdc(8'h02, 8'hc4);
      wait_cnt(1'b1, d);
      repeat (8) @(negedge clk_sys);
   endtask : shot
   task automatic alert(input logic e);
      repeat (4) @(negedge clk_sys);
      chk("alert_n", {7'h00, alert_n_q}, {7'h00, e});
   endtask : alert
   // ==========================================================
   // main sequence; no write ever goes above 0x14
   initial
   begin
      {sys_rst, bus_wr_stb, bus_wr_first, bus_rd_stb, alert_resp_stb, standby_pin_n, tb_open} = 7'b1000000;
      bus_wr_data = 8'h00;
      tb_local = 8'h4f;
      tb_remote = 11'h090;
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      for (i = 0; i < 19; i++) rdc(RA[i], RV[i]);
      alert(1'b1);
      wr(8'h00, 8'h55);
      rdc(8'h00, 8'h80);
      wr(8'h0b, 8'h4f);
      shot(1'b0);
      chk("starts", 8'(n_start), 8'h01);
      rdc(8'h00, 8'h4f);
      rdc(8'h01, 8'h12);
      rdc(8'h10, 8'h00);
      rdc(8'h02, 8'h00);
      repeat (30) @(negedge clk_sys);
      chk("starts", 8'(n_start), 8'h01);
      wr(8'h11, 8'h01);
      wr(8'h12, 8'h20);
      tb_local = 8'h50;
      tb_open = 1'b1;
      shot(1'b0);
      rdc(8'h01, 8'h13);
      rdc(8'h10, 8'h20);
      rdc(8'h02, 8'h44);
      rdc(8'h02, 8'h44);
      alert(1'b0);
      tb_local = 8'h20;
      tb_open = 1'b0;
      shot(1'b1);
      rdc(8'h02, 8'h44);
      rdc(8'h02, 8'h00);
      alert(1'b0);
      wr(8'h09, 8'h80);
      alert(1'b1);
      wr(8'h09, 8'h00);
      alert(1'b0);
      @(negedge clk_sys) alert_resp_stb = 1'b1;
      @(negedge clk_sys) alert_resp_stb = 1'b0;
      alert(1'b1);
      for (i = 0; i < 2; i++)
      begin
         wr(8'h11, SOH[i]);
         wr(8'h12, SOL[i]);
         tb_remote = SM[i];
         shot(1'b0);
         rdc(8'h01, SH[i]);
         rdc(8'h10, SL[i]);
         rdc(8'h02, SS[i]);
      end
      wr(8'h09, 8'h40);
      standby_pin_n = 1'b1;
      tb_local = 8'h33;
      k = n_start;
      repeat (40) @(negedge clk_sys);
      chk("starts", 8'(n_start - k), 8'h00);
      rdc(8'h00, 8'h20);
      wr(8'h09, 8'h00);
      wait_cnt(1'b0, k);
      k = n_done;
      wait_cnt(1'b1, k);
      rdc(8'h00, 8'h33);
      // standby taken in mid-conversion drops that result
      standby_pin_n = 1'b0;
      tb_local = 8'h44;
      repeat (40) @(negedge clk_sys);
      rdc(8'h00, 8'h33);
      end_sim;
   end
endmodule : tmr_regs_test
